// file: src/arc_pkg.sv
// Package with register map, field layout and encodings of the clock source and route registers.
package arc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] RX_CH8_CFG_ADDR   = 8'h2f;
  localparam logic [7:0] CLK_SRC_A_ADDR    = 8'h32;
  localparam logic [7:0] CLK_SRC_B_ADDR    = 8'h33;

  localparam logic [7:0] RX_CH8_CFG_RESET  = 8'h07;
  localparam logic [7:0] CLK_SRC_A_RESET   = 8'h00;
  localparam logic [7:0] CLK_SRC_B_RESET   = 8'h00;

  localparam int unsigned ROUTE_LSB        = 5;
  localparam int unsigned ROUTE_W          = 2;
  localparam int unsigned SLOT_LSB         = 0;
  localparam int unsigned SLOT_W           = 5;
  localparam int unsigned PRESC_LSB        = 6;
  localparam int unsigned PRESC_W          = 2;
  localparam int unsigned PRI_SEL_LSB      = 3;
  localparam int unsigned SEL_W            = 3;
  localparam int unsigned SEC_SEL_LSB      = 4;

  localparam logic [7:0] RX_CH8_WMASK      = 8'h7f;
  localparam logic [7:0] CLK_SRC_A_WMASK   = 8'hf8;
  localparam logic [7:0] CLK_SRC_B_WMASK   = 8'h70;

  localparam logic [1:0] ROUTE_OFF         = 2'h0;
  localparam logic [1:0] ROUTE_DAC         = 2'h1;
  localparam logic [1:0] ROUTE_ADC_LOOP    = 2'h2;
  localparam logic [1:0] ROUTE_CASCADE     = 2'h3;

  localparam logic [2:0] SRC_PLL           = 3'h0;
  localparam logic [2:0] SRC_PRI_BCLK      = 3'h1;
  localparam logic [2:0] SRC_SEC_BCLK      = 3'h2;
  localparam logic [2:0] SRC_CTRL_CLK      = 3'h3;
  localparam logic [2:0] SRC_OSC           = 3'h4;
  localparam logic [2:0] SRC_DSP           = 3'h5;

  localparam logic [4:0] SLOT_RIGHT_BASE   = 5'h10;
endpackage : arc_pkg

// file: src/arc_src_decode.sv
// One-hot decoder for a bit-clock divider source select with a per-end reserved code.
`timescale 1ns/1ps
module arc_src_decode #(
  parameter logic [2:0] RSV_CODE = 3'h1
) (
  input  wire logic [2:0] sel,
  output logic      [5:0] oneHot,
  output logic            reserved
);
  always_comb begin
    oneHot   = 6'h00;
    reserved = 1'b0;
    if (sel > arc_pkg::SRC_DSP || sel == RSV_CODE) begin
      reserved = 1'b1;
    end else begin
      oneHot[sel] = 1'b1;
    end
  end
endmodule : arc_src_decode

// file: src/arc_route_clk_regs.sv
// Register slice for secondary port channel 8 routing and clock source selection.
`timescale 1ns/1ps
module arc_route_clk_regs (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regAddrHit,
  output logic      [1:0] rxCh8Route,
  output logic            rxCh8Enable,
  output logic      [4:0] rxCh8Slot,
  output logic            rxCh8RightSlot,
  output logic      [3:0] rxCh8LrSlot,
  output logic      [3:0] prescalerSrcOneHot,
  output logic      [5:0] priBitclkSrcOneHot,
  output logic      [5:0] secBitclkSrcOneHot,
  output logic            srcSelReserved
);
  typedef enum logic [1:0] {
    REG_NONE,
    REG_RX_CH8,
    REG_SRC_A,
    REG_SRC_B
  } arc_reg_sel_t;

  logic [7:0] rxCfg_q;
  logic [7:0] rxCfg_d;
  logic [7:0] srcA_q;
  logic [7:0] srcA_d;
  logic [7:0] srcB_q;
  logic [7:0] srcB_d;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic       hit_q;
  logic       hit_d;
  logic [5:0] priHot;
  logic [5:0] secHot;
  logic       priRsv;
  logic       secRsv;
  logic [1:0] routeOut_q;
  logic [1:0] routeOut_d;
  logic       enOut_q;
  logic       enOut_d;
  logic [4:0] slotOut_q;
  logic [4:0] slotOut_d;
  logic       right_q;
  logic       right_d;
  logic [3:0] lr_q;
  logic [3:0] lr_d;
  logic [3:0] presc_q;
  logic [3:0] presc_d;
  logic [5:0] pri_q;
  logic [5:0] pri_d;
  logic [5:0] sec_q;
  logic [5:0] sec_d;
  logic       rsv_q;
  logic       rsv_d;

  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (cur & ~mask) | (wd & mask);
  endfunction : merge

  // Address decode shared by the write path and the read path.
  function automatic arc_reg_sel_t regSelect(input logic [7:0] addr);
    case (addr)
      arc_pkg::RX_CH8_CFG_ADDR: regSelect = REG_RX_CH8;
      arc_pkg::CLK_SRC_A_ADDR:  regSelect = REG_SRC_A;
      arc_pkg::CLK_SRC_B_ADDR:  regSelect = REG_SRC_B;
      default:                  regSelect = REG_NONE;
    endcase
  endfunction : regSelect

  function automatic logic [3:0] prescDecode(input logic [1:0] code);
    prescDecode       = 4'h0;
    prescDecode[code] = 1'b1;
  endfunction : prescDecode

  // Derived outputs leave reset matching the reset contents of their registers.
  // Both divider selects reset to the PLL code, which is never a reserved code.
  localparam logic [1:0] ROUTE_RST =
    arc_pkg::RX_CH8_CFG_RESET[arc_pkg::ROUTE_LSB +: arc_pkg::ROUTE_W];
  localparam logic [4:0] SLOT_RST  =
    arc_pkg::RX_CH8_CFG_RESET[arc_pkg::SLOT_LSB +: arc_pkg::SLOT_W];
  localparam logic       EN_RST    = (ROUTE_RST != arc_pkg::ROUTE_OFF);
  localparam logic       RIGHT_RST = (SLOT_RST >= arc_pkg::SLOT_RIGHT_BASE);
  localparam logic [3:0] LR_RST    = SLOT_RST[3:0];
  localparam logic [3:0] PRESC_RST =
    prescDecode(arc_pkg::CLK_SRC_A_RESET[arc_pkg::PRESC_LSB +: arc_pkg::PRESC_W]);
  localparam logic [5:0] PRI_RST   =
    6'h01 << arc_pkg::CLK_SRC_A_RESET[arc_pkg::PRI_SEL_LSB +: arc_pkg::SEL_W];
  localparam logic [5:0] SEC_RST   =
    6'h01 << arc_pkg::CLK_SRC_B_RESET[arc_pkg::SEC_SEL_LSB +: arc_pkg::SEL_W];

  arc_src_decode #(.RSV_CODE(arc_pkg::SRC_PRI_BCLK)) u_priDec (
    .sel      (srcA_q[arc_pkg::PRI_SEL_LSB +: arc_pkg::SEL_W]),
    .oneHot   (priHot),
    .reserved (priRsv)
  );

  arc_src_decode #(.RSV_CODE(arc_pkg::SRC_SEC_BCLK)) u_secDec (
    .sel      (srcB_q[arc_pkg::SEC_SEL_LSB +: arc_pkg::SEL_W]),
    .oneHot   (secHot),
    .reserved (secRsv)
  );

  always_comb begin
    rxCfg_d = rxCfg_q;
    srcA_d  = srcA_q;
    srcB_d  = srcB_q;
    if (regWrEn) begin
      case (regSelect(regAddr))
        REG_RX_CH8: begin
          rxCfg_d = merge(rxCfg_q, regWrData, arc_pkg::RX_CH8_WMASK);
        end
        REG_SRC_A: begin
          srcA_d = merge(srcA_q, regWrData, arc_pkg::CLK_SRC_A_WMASK);
        end
        REG_SRC_B: begin
          srcB_d = merge(srcB_q, regWrData, arc_pkg::CLK_SRC_B_WMASK);
        end
        default: begin
          rxCfg_d = rxCfg_q;
        end
      endcase
    end
  end

  always_comb begin
    hit_d    = 1'b1;
    rdData_d = 8'h00;
    case (regSelect(regAddr))
      REG_RX_CH8: rdData_d = rxCfg_q;
      REG_SRC_A:  rdData_d = srcA_q;
      REG_SRC_B:  rdData_d = srcB_q;
      default:    hit_d    = 1'b0;
    endcase
    // With no read strobe the last answer stands until the next read.
    if (!regRdEn) begin
      rdData_d = rdData_q;
      hit_d    = hit_q;
    end
  end

  always_comb begin
    routeOut_d = rxCfg_q[arc_pkg::ROUTE_LSB +: arc_pkg::ROUTE_W];
    enOut_d    = (routeOut_d != arc_pkg::ROUTE_OFF);
    slotOut_d  = rxCfg_q[arc_pkg::SLOT_LSB +: arc_pkg::SLOT_W];
    right_d    = (slotOut_d >= arc_pkg::SLOT_RIGHT_BASE);
    lr_d       = slotOut_d[3:0];
    presc_d    = prescDecode(srcA_q[arc_pkg::PRESC_LSB +: arc_pkg::PRESC_W]);
    pri_d      = priHot;
    sec_d      = secHot;
    rsv_d      = priRsv | secRsv;
  end

  // Reset acts whatever the enable; a low enable freezes every register of the slice.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxCfg_q <= arc_pkg::RX_CH8_CFG_RESET;
      srcA_q  <= arc_pkg::CLK_SRC_A_RESET;
      srcB_q  <= arc_pkg::CLK_SRC_B_RESET;
    end else if (clkEn) begin
      rxCfg_q <= rxCfg_d;
      srcA_q  <= srcA_d;
      srcB_q  <= srcB_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
      hit_q    <= 1'b0;
    end else if (clkEn) begin
      rdData_q <= rdData_d;
      hit_q    <= hit_d;
    end
  end

  // Derived outputs trail their register by one cycle so that every output is a flip-flop.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      routeOut_q <= ROUTE_RST;
      enOut_q    <= EN_RST;
      slotOut_q  <= SLOT_RST;
      right_q    <= RIGHT_RST;
      lr_q       <= LR_RST;
      presc_q    <= PRESC_RST;
      pri_q      <= PRI_RST;
      sec_q      <= SEC_RST;
      rsv_q      <= 1'b0;
    end else if (clkEn) begin
      routeOut_q <= routeOut_d;
      enOut_q    <= enOut_d;
      slotOut_q  <= slotOut_d;
      right_q    <= right_d;
      lr_q       <= lr_d;
      presc_q    <= presc_d;
      pri_q      <= pri_d;
      sec_q      <= sec_d;
      rsv_q      <= rsv_d;
    end
  end

  assign regRdData          = rdData_q;
  assign regAddrHit         = hit_q;
  assign rxCh8Route         = routeOut_q;
  assign rxCh8Enable        = enOut_q;
  assign rxCh8Slot          = slotOut_q;
  assign rxCh8RightSlot     = right_q;
  assign rxCh8LrSlot        = lr_q;
  assign prescalerSrcOneHot = presc_q;
  assign priBitclkSrcOneHot = pri_q;
  assign secBitclkSrcOneHot = sec_q;
  assign srcSelReserved     = rsv_q;
endmodule : arc_route_clk_regs

// file: sim/arc_route_clk_chk.sv
// Checker for the route and clock source register slice.
`timescale 1ns/1ps
module arc_route_clk_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       clkEn,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regAddrHit,
  input wire logic [1:0] rxCh8Route,
  input wire logic       rxCh8Enable,
  input wire logic [4:0] rxCh8Slot,
  input wire logic       rxCh8RightSlot,
  input wire logic [3:0] rxCh8LrSlot,
  input wire logic [3:0] prescalerSrcOneHot,
  input wire logic [5:0] priBitclkSrcOneHot,
  input wire logic [5:0] secBitclkSrcOneHot,
  input wire logic       srcSelReserved
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rdOn = regRdEn && clkEn;
  chk_route_enable: assert property (rxCh8Enable == (rxCh8Route != 2'h0))
    else $error("enable does not follow route");
  chk_slot_split: assert property (rxCh8RightSlot == rxCh8Slot[4] &&
    rxCh8LrSlot == rxCh8Slot[3:0]) else $error("slot split wrong");
  chk_presc_onehot: assert property ($onehot(prescalerSrcOneHot))
    else $error("prescaler select not one-hot");
  chk_pri_code_gap: assert property (!priBitclkSrcOneHot[1] &&
    $countones(priBitclkSrcOneHot) <= 1) else $error("primary select wrong");
  chk_sec_code_gap: assert property (!secBitclkSrcOneHot[2] &&
    $countones(secBitclkSrcOneHot) <= 1) else $error("secondary select wrong");
  chk_rsv_flag: assert property (srcSelReserved ==
    (priBitclkSrcOneHot == 6'h00 || secBitclkSrcOneHot == 6'h00)) else $error("flag wrong");
  chk_route_write: assert property (clkEn && regWrEn && regAddr == 8'h2f ##1 clkEn |=>
    rxCh8Route == $past(regWrData[6:5], 2) && rxCh8Slot == $past(regWrData[4:0], 2))
    else $error("route write not applied");
  chk_rsv_readback: assert property (rdOn && regAddr == 8'h32 |=>
    regRdData[2:0] == 3'h0 && regAddrHit) else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (rdOn && !(regAddr inside {8'h2f, 8'h32, 8'h33}) |=>
    regRdData == 8'h00 && !regAddrHit) else $error("unmapped read nonzero");
  cover property (rdOn && regAddr == 8'h33);
  cover property (rxCh8Route == 2'h3);
  cover property (srcSelReserved);
endmodule : arc_route_clk_chk

bind arc_route_clk_regs arc_route_clk_chk u_chk (.*);

// file: sim/tb.sv
// Self-checking bench for the route and clock source register slice.
`timescale 1ns/1ps
module tb;
  logic       clk = 0, resetn = 0, clkEn = 1, regWrEn = 0, regRdEn = 0, taken = 0;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData;
  logic       regAddrHit, rxCh8Enable, rxCh8RightSlot, srcSelReserved;
  logic [1:0] rxCh8Route;
  logic [4:0] rxCh8Slot;
  logic [3:0] rxCh8LrSlot, prescalerSrcOneHot;
  logic [5:0] priBitclkSrcOneHot, secBitclkSrcOneHot;
  logic [8:0] expQ[$];
  int         error_cnt = 0, checks_done = 0, seed = 95;
  always #2.5 clk = ~clk;
  arc_route_clk_regs dut (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {regWrEn, regAddr, regWrData} = {1'b1, a, d};
    @(negedge clk) regWrEn = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    @(negedge clk) {regRdEn, regAddr} = {1'b1, a};
    expQ.push_back(e);
    @(negedge clk) regRdEn = 0;
  endtask : rd
  function automatic logic [5:0] oh(input logic [2:0] c, input logic [2:0] rsv);
    return (c == rsv || c > 3'h5) ? 6'h00 : 6'h01 << c;
  endfunction : oh
  always @(posedge clk) taken <= regRdEn && clkEn && resetn;
  always @(negedge clk) if (taken) cmp({regAddrHit, regRdData}, expQ.pop_front());
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    $display("unexpected at %0t: run timed out", $time);
    end_of_test();
  end
  initial begin
    logic [31:0] s;
    repeat (8) @(negedge clk);
    resetn = 1;
    rd(8'h2f, 9'h107);
    rd(8'h32, 9'h100);
    rd(8'h33, 9'h100);
    rd(8'h30, 9'h000);
    cmp({rxCh8Slot, prescalerSrcOneHot, priBitclkSrcOneHot}, {5'h07, 4'h1, 6'h01});
    $display("test reset values done");
    for (int r = 0; r < 4; r++) begin
      s = (r < 2) ? 32'd15 + r : $random(seed);
      wr(8'h2f, {1'b1, r[1:0], s[4:0]});
      @(negedge clk);
      cmp({rxCh8Route, rxCh8Enable, rxCh8Slot, rxCh8RightSlot, rxCh8LrSlot},
          {r[1:0], r != 0, s[4:0], s[4], s[3:0]});
      rd(8'h2f, {2'b10, r[1:0], s[4:0]});
    end
    $display("test route and slot done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h32, {c[1:0], c[2:0], 3'h7});
      wr(8'h33, {1'b1, c[2:0], 4'hf});
      @(negedge clk);
      cmp({prescalerSrcOneHot, priBitclkSrcOneHot, secBitclkSrcOneHot, srcSelReserved},
          {4'h1 << c[1:0], oh(c[2:0], 3'h1), oh(c[2:0], 3'h2),
           c == 1 || c == 2 || c > 5});
      rd(8'h32, {1'b1, c[1:0], c[2:0], 3'h0});
      rd(8'h33, {2'b10, c[2:0], 4'h0});
    end
    $display("test clock sources done");
    clkEn = 0;
    wr(8'h33, 8'h50);
    clkEn = 1;
    rd(8'h33, 9'h170);
    resetn = 0;
    @(negedge clk) resetn = 1;
    rd(8'h32, 9'h100);
    rd(8'h2f, 9'h107);
    $display("test freeze and reset done");
    for (int i = 0; i < 8 && expQ.size() > 0; i++) @(negedge clk);
    if (expQ.size() > 0) begin
      error_cnt++;
      $display("unexpected at %0t: read answers still outstanding", $time);
    end
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
endmodule : tb
